/* File: rtl/iq_pair_pkg.sv */
// Constants and types for the interleaved I/Q input pairing block
package iq_pair_pkg;

  localparam int unsigned DATA_W       = 10;
  localparam int unsigned SLEEP_CYCLES = 4;
  localparam int unsigned SLEEP_CNT_W  = 3;

  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_ONE_I  = 2'b01,
    ST_FILTER = 2'b10
  } pair_state_t;

endpackage

/* File: rtl/iq_pair.sv */
// Interleaved I/Q input capture, pairing machine and filter register load
`timescale 1ns/100ps
module iq_pair #(
  parameter int unsigned DATA_W = iq_pair_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [DATA_W-1:0] data_pin,
  input  wire logic              write_pin,
  input  wire logic              select_pin,
  input  wire logic              sample_clk_pin,
  input  wire logic              reset_sleep_pin,
  output logic [DATA_W-1:0]      i_filter_in,
  output logic [DATA_W-1:0]      q_filter_in,
  output logic                   filter_clk,
  output logic [DATA_W-1:0]      i_primary_current_out,
  output logic [DATA_W-1:0]      i_complement_current_out,
  output logic [DATA_W-1:0]      q_primary_current_out,
  output logic [DATA_W-1:0]      q_complement_current_out,
  output logic                   power_down
);
  import iq_pair_pkg::*;

  if (DATA_W != iq_pair_pkg::DATA_W) begin : g_bad_width
    $error("iq_pair: data width must be ten bits");
  end

  localparam logic [SLEEP_CNT_W-1:0] SLEEP_LAST = SLEEP_CNT_W'(SLEEP_CYCLES - 1);
  localparam logic [DATA_W-1:0]      CODE_ALL   = {DATA_W{1'b1}};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [DATA_W-1:0] data_s1_q, data_s2_q;
  logic [3:0]        ctl_s1_q, ctl_s2_q, ctl_s3_q;
  logic              wr_rise, clk_rise;
  logic              sel_s, rs_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_s1_q <= '0;
      data_s2_q <= '0;
      ctl_s1_q  <= '0;
      ctl_s2_q  <= '0;
      ctl_s3_q  <= '0;
    end else begin
      data_s1_q <= data_pin;
      data_s2_q <= data_s1_q;
      ctl_s1_q  <= {reset_sleep_pin, sample_clk_pin, select_pin, write_pin};
      ctl_s2_q  <= ctl_s1_q;
      ctl_s3_q  <= ctl_s2_q;
    end
  end

  // Edges seen on the second and third stages only
  assign wr_rise  = ctl_s2_q[0] & ~ctl_s3_q[0];
  assign sel_s    = ctl_s2_q[1];
  assign clk_rise = ctl_s2_q[2] & ~ctl_s3_q[2];
  assign rs_s     = ctl_s2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Input registers and pending write event
  logic [DATA_W-1:0] i_in_q, i_in_d, q_in_q, q_in_d;
  logic              pend_q, pend_d, pend_sel_q, pend_sel_d;
  logic              ev_write, ev_sel;

  always_comb begin
    i_in_d     = i_in_q;
    q_in_d     = q_in_q;
    pend_d     = pend_q;
    pend_sel_d = pend_sel_q;
    if (wr_rise) begin
      if (sel_s) begin
        i_in_d = data_s2_q;
      end else begin
        q_in_d = data_s2_q;
      end
      pend_d     = 1'b1;
      pend_sel_d = sel_s;
    end
    if (clk_rise) begin
      pend_d = 1'b0;
    end
    // Write on the same cycle as the clock counts for this clock
    ev_write = pend_q | wr_rise;
    ev_sel   = wr_rise ? sel_s : pend_sel_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i_in_q     <= '0;
      q_in_q     <= '0;
      pend_q     <= 1'b0;
      pend_sel_q <= 1'b0;
    end else begin
      i_in_q     <= i_in_d;
      q_in_q     <= q_in_d;
      pend_q     <= pend_d;
      pend_sel_q <= pend_sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset/sleep length counter
  logic [SLEEP_CNT_W-1:0] rs_cnt_q, rs_cnt_d;
  logic                   pd_q, pd_d;

  always_comb begin
    rs_cnt_d = rs_cnt_q;
    pd_d     = pd_q;
    if (!rs_s) begin
      rs_cnt_d = '0;
      pd_d     = 1'b0;
    end else if (clk_rise) begin
      if (rs_cnt_q == SLEEP_LAST) begin
        pd_d = 1'b1;
      end else begin
        rs_cnt_d = rs_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_cnt_q <= '0;
      pd_q     <= 1'b0;
    end else begin
      rs_cnt_q <= rs_cnt_d;
      pd_q     <= pd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pairing state machine and filter clock
  pair_state_t       st_q, st_d;
  logic              fclk_q, fclk_d;
  logic [DATA_W-1:0] i_flt_q, i_flt_d, q_flt_q, q_flt_d;

  always_comb begin
    st_d    = st_q;
    fclk_d  = fclk_q;
    i_flt_d = i_flt_q;
    q_flt_d = q_flt_q;
    if (clk_rise) begin
      fclk_d = ~fclk_q;
      if (rs_s) begin
        st_d   = ST_RESET;
        fclk_d = 1'b0;
      end else begin
        case (st_q)
          ST_RESET: begin
            if (ev_write && ev_sel) begin
              st_d = ST_ONE_I;
            end
          end
          ST_ONE_I: begin
            if (ev_write) begin
              st_d = ST_FILTER;
            end
          end
          ST_FILTER: begin
            if (ev_write && ev_sel) begin
              st_d = ST_ONE_I;
            end else if (ev_write) begin
              st_d = ST_RESET;
            end
          end
          default: begin
            st_d = ST_RESET;
          end
        endcase
        if (st_d == ST_FILTER && st_q != ST_FILTER) begin
          i_flt_d = i_in_d;
          q_flt_d = q_in_d;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= ST_RESET;
      fclk_q  <= 1'b0;
      i_flt_q <= '0;
      q_flt_q <= '0;
    end else begin
      st_q    <= st_d;
      fclk_q  <= fclk_d;
      i_flt_q <= i_flt_d;
      q_flt_q <= q_flt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel output codes, both loaded on each sample clock rise outside power down, cleared every cycle in power down
  logic [DATA_W-1:0] ip_q, ip_d, ic_q, ic_d, qp_q, qp_d, qc_q, qc_d;

  always_comb begin
    ip_d = ip_q;
    ic_d = ic_q;
    qp_d = qp_q;
    qc_d = qc_q;
    if (pd_q) begin
      ip_d = '0;
      ic_d = '0;
      qp_d = '0;
      qc_d = '0;
    end else if (clk_rise) begin
      ip_d = i_flt_q;
      ic_d = CODE_ALL - i_flt_q;
      qp_d = q_flt_q;
      qc_d = CODE_ALL - q_flt_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ip_q <= '0;
      ic_q <= '0;
      qp_q <= '0;
      qc_q <= '0;
    end else begin
      ip_q <= ip_d;
      ic_q <= ic_d;
      qp_q <= qp_d;
      qc_q <= qc_d;
    end
  end

  assign i_filter_in              = i_flt_q;
  assign q_filter_in              = q_flt_q;
  assign filter_clk               = fclk_q;
  assign i_primary_current_out    = ip_q;
  assign i_complement_current_out = ic_q;
  assign q_primary_current_out    = qp_q;
  assign q_complement_current_out = qc_q;
  assign power_down               = pd_q;

endmodule

/* File: verif/iq_pair_sva.sv */
// Checker for the pairing block outputs
`timescale 1ns/100ps
module iq_pair_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sample_clk_pin,
  input wire logic       reset_sleep_pin,
  input wire logic [9:0] i_filter_in,
  input wire logic [9:0] q_filter_in,
  input wire logic       filter_clk,
  input wire logic [9:0] i_primary_current_out,
  input wire logic [9:0] i_complement_current_out,
  input wire logic [9:0] q_primary_current_out,
  input wire logic [9:0] q_complement_current_out,
  input wire logic       power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence awake_s; !power_down ##1 !power_down ##1 !power_down; endsequence
  sequence pin_held_s; reset_sleep_pin [*6]; endsequence
  i_comp_a: assert property ($changed(i_complement_current_out) && !power_down
    |-> i_primary_current_out + i_complement_current_out == 10'h3FF) else $error("i complement");
  q_comp_a: assert property ($changed(q_complement_current_out) && !power_down
    |-> q_primary_current_out + q_complement_current_out == 10'h3FF) else $error("q complement");
  filt_edge_a: assert property (awake_s ##0 ($changed(i_filter_in) || $changed(q_filter_in))
    |-> $past(sample_clk_pin)) else $error("filter load off clock");
  out_follow_a: assert property (!power_down && ($changed(i_primary_current_out)
    || $changed(q_primary_current_out)) |-> i_primary_current_out == $past(i_filter_in)
    && q_primary_current_out == $past(q_filter_in)) else $error("outputs not paired");
  fclk_edge_a: assert property (awake_s ##0 $changed(filter_clk)
    |-> $past(sample_clk_pin)) else $error("filter clock off edge");
  pd_zero_a: assert property ($past(power_down) && power_down
    |-> i_primary_current_out == 10'h000 && q_primary_current_out == 10'h000) else $error("pd out");
  pd_cause_a: assert property ($rose(power_down) |-> $past(reset_sleep_pin, 2))
    else $error("power down without pin");
  pd_drop_a: assert property ($fell(reset_sleep_pin) |-> ##[1:8] !power_down)
    else $error("power down stuck");
  rst_hold_a: assert property (pin_held_s |-> $stable(i_filter_in) && $stable(q_filter_in))
    else $error("filter load in reset");
endmodule

/* File: verif/host_drv.sv */
// Host partner model driving the interleaved data pins
`timescale 1ns/100ps
module host_drv (
  input  wire logic  clk,
  output logic [9:0] data_pin,
  output logic       write_pin,
  output logic       select_pin,
  output logic       sample_clk_pin,
  output logic       reset_sleep_pin
);
  initial begin
    data_pin = 10'h155;
    write_pin = 1'b0;
    select_pin = 1'b0;
    sample_clk_pin = 1'b0;
    reset_sleep_pin = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic sel, input logic [9:0] d);
    data_pin = d;
    select_pin = sel;
    hold(4);
    write_pin = 1'b1;
    hold(4);
    write_pin = 1'b0;
    hold(4);
    data_pin = ~d;
  endtask
  task automatic tick();
    sample_clk_pin = 1'b1;
    hold(4);
    sample_clk_pin = 1'b0;
    hold(4);
  endtask
  task automatic slp(input logic lvl, input int n);
    reset_sleep_pin = lvl;
    repeat (n) tick();
    hold(6);
  endtask
endmodule

/* File: verif/test_interleaved_iq_input_pairing.sv */
// Self-checking bench for the pairing block
`timescale 1ns/100ps
module test_interleaved_iq_input_pairing;
  import iq_pair_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [9:0] data_pin, i_fi, q_fi, i_po, i_co, q_po, q_co;
  logic       write_pin, select_pin, sample_clk_pin, reset_sleep_pin, filter_clk, power_down;
  logic       fc;
  int         n_errors = 0;
  int         total_checks = 0;
  always #20 clk = ~clk;
  iq_pair dut_u (.clk, .rst, .data_pin, .write_pin, .select_pin, .sample_clk_pin,
    .reset_sleep_pin, .i_filter_in(i_fi), .q_filter_in(q_fi), .filter_clk,
    .i_primary_current_out(i_po), .i_complement_current_out(i_co),
    .q_primary_current_out(q_po), .q_complement_current_out(q_co), .power_down);
  host_drv h (.clk, .data_pin, .write_pin, .select_pin, .sample_clk_pin, .reset_sleep_pin);
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pair(input logic [9:0] ei, input logic [9:0] eq);
    chk(i_fi, ei);
    chk(q_fi, eq);
    // Outputs take the filter pair at the next sample clock rise
    h.tick();
    chk(i_po, ei);
    chk(q_po, eq);
    chk(i_co, 10'h3FF - ei);
    chk(q_co, 10'h3FF - eq);
  endtask
  task automatic wt(input logic s, input logic [9:0] d);
    h.wr(s, d);
    h.tick();
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic s_pair();
    h.slp(1'b1, 2);
    chk({9'h000, power_down}, 10'h000);
    h.slp(1'b0, 0);
    wt(1'b1, 10'h3FF);
    chk_pair(10'h000, 10'h000);
    fc = filter_clk;
    wt(1'b0, 10'h000);
    chk({9'h000, filter_clk}, {9'h000, ~fc});
    chk_pair(10'h3FF, 10'h000);
  endtask
  task automatic s_hold();
    wt(1'b1, 10'h155);
    chk_pair(10'h3FF, 10'h000);
    wt(1'b0, 10'h2AA);
    chk_pair(10'h155, 10'h2AA);
  endtask
  task automatic s_stuck();
    wt(1'b1, 10'h0F0);
    wt(1'b1, 10'h30F);
    chk_pair(10'h30F, 10'h2AA);
    wt(1'b1, 10'h111);
    chk_pair(10'h30F, 10'h2AA);
  endtask
  task automatic s_resync();
    wt(1'b0, 10'h222);
    chk_pair(10'h111, 10'h222);
    wt(1'b0, 10'h333);
    wt(1'b0, 10'h044);
    chk_pair(10'h111, 10'h222);
    wt(1'b1, 10'h155);
    wt(1'b0, 10'h0AA);
    chk_pair(10'h155, 10'h0AA);
  endtask
  task automatic s_sleep();
    h.slp(1'b1, 5);
    chk({9'h000, power_down}, 10'h001);
    chk(i_po, 10'h000);
    h.slp(1'b0, 0);
    chk({9'h000, power_down}, 10'h000);
    wt(1'b1, 10'h001);
    wt(1'b0, 10'h002);
    chk_pair(10'h001, 10'h002);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    h.hold(2);
    s_pair();
    s_hold();
    s_stuck();
    s_resync();
    s_sleep();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule
bind iq_pair iq_pair_sva chk_u (.clk, .rst, .sample_clk_pin, .reset_sleep_pin, .i_filter_in,
  .q_filter_in, .filter_clk, .i_primary_current_out, .i_complement_current_out,
  .q_primary_current_out, .q_complement_current_out, .power_down);
